/* dv/volume_ramp_automute_tb.sv */
module volume_ramp_automute_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import vramp_pkg::*;
    logic clk_sys, nrst, clk_error, power_outage, smp_valid, smp_ready, out_valid, out_ready;
    logic mute_left, mute_right, emerg_active, go, zero_l, zero_r, hold_ready, ready_rand, mon_on;
    vramp_reg_req_t reg_req;
    vramp_sample_t smp_data, out_data;
    vramp_sample_t sent[$];
    logic [7:0] reg_rdata, digital_volume_level, volume_out, last_vol, rv, wv;
    int seed = 1863;
    int bad_count, checked, beats, taken, hs_since, nchg, exp_step, exp_gap;

    vramp_top dut (.clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .clk_error(clk_error), .power_outage(power_outage), .digital_volume_level(digital_volume_level),
        .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .volume_out(volume_out), .mute_left(mute_left),
        .mute_right(mute_right), .emerg_active(emerg_active));
    vramp_src_model src (.clk_sys(clk_sys), .nrst(nrst), .go(go), .zero_l(zero_l), .zero_r(zero_r),
        .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data));

    // Clock at 40 MHz
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Counts handshakes, drives the sink and checks every ramp update short of the mute code
    always @(posedge clk_sys)
    begin
        out_ready <= hold_ready ? 1'b0 : (ready_rand ? (($random(seed) & 3) != 0) : 1'b1);
        if (smp_valid && smp_ready) taken++;
        if (smp_valid && smp_ready) sent.push_back(smp_data);
        if (out_valid && out_ready) chk("out_data", sent.pop_front(), out_data);
        if (out_valid && out_ready) hs_since++;
        if (out_valid && out_ready) beats++;
        if (mon_on && volume_out !== last_vol && last_vol !== VRAMP_VOL_MUTE && volume_out !== VRAMP_VOL_MUTE)
        begin
            chk("ramp_step", exp_step, 32'(volume_out - last_vol));
            if (nchg > 0) chk("ramp_gap", exp_gap, hs_since);
            nchg++;
        end
        if (volume_out !== last_vol) hs_since = 0;
        last_vol = volume_out;
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b1, addr: a, data: d};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_req.addr <= a;
        repeat (2) @(posedge clk_sys);
        d = reg_rdata;
    endtask
    // Waits until n more output beats have passed, bounded
    task automatic run_beats(input int n);
        int b0;
        b0 = beats;
        repeat (n * 8 + 100) if (beats - b0 < n) @(posedge clk_sys);
    endtask
    // Zero-run length in samples; reserved code 3 behaves as the longest
    function automatic int run_len(input logic [2:0] c);
        int tus[8] = '{11500, 53000, 106500, 5330000, 535000, 1065000, 2665000, 5330000};
        return tus[c] * 96 / 1000;
    endfunction
    // One emergency ramp from a random start level down to mute, then release
    task automatic ramp(input logic [1:0] spd, input logic [1:0] stp, input logic use_pwr);
        digital_volume_level <= 8'($random(seed)) & 8'h7f;
        reg_wr(VRAMP_OFS_EMERG, {spd, stp, 4'h0});
        exp_step = 8 >> stp;
        exp_gap = 1 << spd;
        nchg = 0;
        @(posedge clk_sys);
        mon_on = 1'b1;
        if (use_pwr) power_outage <= 1'b1;
        else clk_error <= 1'b1;
        repeat (4000) if (volume_out !== VRAMP_VOL_MUTE) @(posedge clk_sys);
        chk("ramp_muted", VRAMP_VOL_MUTE, volume_out);
        chk("ramp_active", 1, emerg_active);
        chk("ramp_updates", 1, nchg > 0);
        mon_on = 1'b0;
        clk_error <= 1'b0;
        power_outage <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk("vol_idle", digital_volume_level, volume_out);
        chk("ramp_idle", 0, emerg_active);
    endtask
    // Clears both runs, then zero runs per channel against the expected mute levels
    task automatic amute(input logic [2:0] cfg, input logic [2:0] rc, input logic zl, input logic zr,
        input logic el, input logic er);
        reg_wr(VRAMP_OFS_ZCFG, {5'h00, cfg});
        reg_wr(VRAMP_OFS_ZDUR, {5'h00, rc});
        zero_l <= 1'b0;
        zero_r <= 1'b0;
        run_beats(30);
        chk("release", 2'b00, {mute_left, mute_right});
        zero_l <= zl;
        zero_r <= zr;
        run_beats(run_len(0) - 5);
        chk("mute_early", 2'b00, {mute_left, mute_right});
        run_beats(run_len(rc) - run_len(0) + 40);
        chk("mute_end", {el, er}, {mute_left, mute_right});
    endtask
    task automatic print_verdict;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        #1500000;
        bad_count++;
        print_verdict();
    end
    // Main sequence
    initial
    begin
        nrst = 1'b0;
        reg_req = '0;
        {clk_error, power_outage, go, zero_l, zero_r, mon_on, ready_rand} = '0;
        hold_ready = 1'b1;
        out_ready = 1'b0;
        digital_volume_level = VRAMP_VOL_UNITY;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        reg_rd(VRAMP_OFS_EMERG, rv);
        chk("rst_emerg", VRAMP_RST_EMERG, rv);
        reg_rd(VRAMP_OFS_ZCFG, rv);
        chk("rst_zcfg", VRAMP_RST_ZCFG, rv);
        reg_rd(VRAMP_OFS_ZDUR, rv);
        chk("rst_zdur", VRAMP_RST_ZDUR, rv);
        // Buffer fills while the sink stalls, then drains completely
        go <= 1'b1;
        repeat (40) @(posedge clk_sys);
        chk("fill_taken", 9, taken);
        chk("fill_refuse", 0, smp_ready);
        go <= 1'b0;
        hold_ready = 1'b0;
        repeat (40) @(posedge clk_sys);
        chk("drained", taken, beats);
        // Read-write registers and one unmapped place
        for (int a = 0; a < 4; a++)
        begin
            wv = 8'($random(seed));
            reg_wr(VRAMP_OFS_EMERG + 8'(a), wv);
            reg_rd(VRAMP_OFS_EMERG + 8'(a), rv);
            chk("reg_rw", (a == 3) ? 8'h00 : wv, rv);
        end
        // Instant mute does not wait for any sample
        reg_wr(VRAMP_OFS_EMERG, {VRAMP_SPD_INSTANT, 6'h00});
        clk_error <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("instant_mute", VRAMP_VOL_MUTE, volume_out);
        clk_error <= 1'b0;
        repeat (4) @(posedge clk_sys);
        go <= 1'b1;
        for (int i = 0; i < 12; i++)
            ramp(2'(i % 3), 2'(i / 3), 1'(i % 2));
        ready_rand = 1'b1;
        amute(3'b011, 3'h0, 1'b1, 1'b0, 1'b1, 1'b0);
        amute(3'b111, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        amute(3'b111, 3'h1, 1'b1, 1'b1, 1'b1, 1'b1);
        amute(3'b010, 3'h0, 1'b1, 1'b1, 1'b0, 1'b1);
        amute(3'b011, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        print_verdict();
    end
endmodule // volume_ramp_automute_tb

/* dv/vramp_src_model.sv */
module vramp_src_model
    import vramp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Control from the bench
    input wire logic go,
    input wire logic zero_l,
    input wire logic zero_r,
    // Sample stream towards the block
    output logic smp_valid,
    input wire logic smp_ready,
    output vramp_sample_t smp_data
);
    timeunit 1ns;
    timeprecision 100ps;
    int seed = 1863;
    // Known idle values before the first edge
    initial
    begin
        smp_valid = 1'b0;
        smp_data = '0;
    end
    // Offers a sample on about three cycles in four and holds it until taken
    always @(posedge clk_sys)
    begin
        if (!nrst)
            smp_valid <= 1'b0;
        else if (!smp_valid || smp_ready)
        begin
            smp_valid <= go && (($random(seed) & 3) != 0);
            // Idle data keeps changing so a stale word is never mistaken for a live one
            smp_data.left <= zero_l ? '0 : 24'($random(seed)) | 24'h00_0001;
            smp_data.right <= zero_r ? '0 : 24'($random(seed)) | 24'h00_0100;
        end
    end
endmodule // vramp_src_model

/* src/vramp_fifo.sv */
// The input buffer module sits beside its only user, with the rest of the block's logic

/* src/vramp_pkg.sv */
package vramp_pkg;
    // Register offsets on the control port
    localparam logic [7:0] VRAMP_OFS_EMERG = 8'h4f;
    localparam logic [7:0] VRAMP_OFS_ZCFG = 8'h50;
    localparam logic [7:0] VRAMP_OFS_ZDUR = 8'h51;
    // Reset values
    localparam logic [7:0] VRAMP_RST_EMERG = 8'h30;
    localparam logic [7:0] VRAMP_RST_ZCFG = 8'h07;
    localparam logic [7:0] VRAMP_RST_ZDUR = 8'h00;
    // Field positions
    localparam int VRAMP_SPD_HI = 7;
    localparam int VRAMP_SPD_LO = 6;
    localparam int VRAMP_STP_HI = 5;
    localparam int VRAMP_STP_LO = 4;
    localparam int VRAMP_EN_L = 0;
    localparam int VRAMP_EN_R = 1;
    localparam int VRAMP_JOINT = 2;
    localparam int VRAMP_TL_HI = 6;
    localparam int VRAMP_TL_LO = 4;
    localparam int VRAMP_TR_HI = 2;
    localparam int VRAMP_TR_LO = 0;
    // Volume codes, 0.5 dB each
    localparam logic [7:0] VRAMP_VOL_MUTE = 8'hff;
    localparam logic [7:0] VRAMP_VOL_UNITY = 8'h30;
    // Speed codes
    localparam logic [1:0] VRAMP_SPD_INSTANT = 2'h3;
    // Sample rate the zero-run times are specified at
    localparam int VRAMP_REF_RATE_HZ = 96000;
    // Zero-run times in microseconds, per code (code 3 reserved, kept at longest)
    localparam int VRAMP_T0_US = 11500;
    localparam int VRAMP_T1_US = 53000;
    localparam int VRAMP_T2_US = 106500;
    localparam int VRAMP_T4_US = 535000;
    localparam int VRAMP_T5_US = 1065000;
    localparam int VRAMP_T6_US = 2665000;
    localparam int VRAMP_T7_US = 5330000;
    localparam int VRAMP_CNT_W = 20;
    localparam int VRAMP_SAMPLE_W = 24;
    localparam int VRAMP_FIFO_DEPTH = 8;
    // One stereo sample
    typedef struct packed {
        logic [VRAMP_SAMPLE_W-1:0] left;
        logic [VRAMP_SAMPLE_W-1:0] right;
    } vramp_sample_t;
    // Register write request
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } vramp_reg_req_t;
    // Samples per zero-run code at the reference rate
    function automatic logic [VRAMP_CNT_W-1:0] vramp_run_len(input logic [2:0] code);
        longint us;
        case (code)
            3'h0: us = VRAMP_T0_US;
            3'h1: us = VRAMP_T1_US;
            3'h2: us = VRAMP_T2_US;
            3'h4: us = VRAMP_T4_US;
            3'h5: us = VRAMP_T5_US;
            3'h6: us = VRAMP_T6_US;
            default: us = VRAMP_T7_US;
        endcase
        vramp_run_len = VRAMP_CNT_W'((us * VRAMP_REF_RATE_HZ) / 1000000);
    endfunction
    typedef enum logic [1:0] {
        VRAMP_ST_IDLE = 2'b00,
        VRAMP_ST_RAMP = 2'b01,
        VRAMP_ST_MUTED = 2'b11
    } vramp_state_t;
endpackage : vramp_pkg

/* src/vramp_top.sv */
module vramp_top
    import vramp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port
    input wire vramp_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Fault triggers, level
    input wire logic clk_error,
    input wire logic power_outage,
    // Volume setting from the normal path
    input wire logic [7:0] digital_volume_level,
    // Sample stream in
    input wire logic smp_valid,
    output logic smp_ready,
    input wire vramp_sample_t smp_data,
    // Sample stream out, one word per consumed input sample
    output logic out_valid,
    input wire logic out_ready,
    output vramp_sample_t out_data,
    // Status
    output logic [7:0] volume_out,
    output logic mute_left,
    output logic mute_right,
    output logic emerg_active
);
    localparam logic [2:0] VRAMP_DIV_MAX = 3'h3;
    logic [7:0] emerg_reg, zcfg_reg, zdur_reg;
    logic [7:0] rdata_reg, rdata_next;
    logic [VRAMP_CNT_W-1:0] zl_reg, zr_reg;
    logic [7:0] vol_reg, vol_next;
    logic [2:0] div_reg;
    vramp_state_t st_reg, st_next;
    logic mute_l_reg, mute_r_reg, out_valid_reg;
    // Registered copy of the not-idle decode, so the status pin comes from a flip-flop
    logic emerg_act_reg;
    vramp_sample_t out_data_reg;
    logic f_valid, f_ready;
    vramp_sample_t f_data;

    // Input buffering
    vramp_fifo #(.WIDTH($bits(vramp_sample_t)), .DEPTH(VRAMP_FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_valid(smp_valid),
        .in_ready(smp_ready),
        .in_data(smp_data),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // A sample advances only when the output slot is free
    assign f_ready = !out_valid_reg || out_ready;
    wire smp_tick = f_valid && f_ready;

    // Register write decode and readback
    wire wr_emerg = reg_req.wr && (reg_req.addr == VRAMP_OFS_EMERG);
    wire wr_zcfg = reg_req.wr && (reg_req.addr == VRAMP_OFS_ZCFG);
    wire wr_zdur = reg_req.wr && (reg_req.addr == VRAMP_OFS_ZDUR);
    assign rdata_next = (reg_req.addr == VRAMP_OFS_EMERG) ? emerg_reg :
                        (reg_req.addr == VRAMP_OFS_ZCFG) ? zcfg_reg :
                        (reg_req.addr == VRAMP_OFS_ZDUR) ? zdur_reg : 8'h00;

    // Field decode
    wire [1:0] e_speed = emerg_reg[VRAMP_SPD_HI:VRAMP_SPD_LO];
    wire [1:0] e_step = emerg_reg[VRAMP_STP_HI:VRAMP_STP_LO];
    wire [2:0] div_lim = (e_speed == 2'h0) ? 3'h0 : (e_speed == 2'h1) ? 3'h1 : VRAMP_DIV_MAX;
    wire [7:0] step_codes = 8'h01 << (2'h3 - e_step);
    wire emerg_trig = clk_error || power_outage;
    wire [VRAMP_CNT_W-1:0] len_l = vramp_run_len(zdur_reg[VRAMP_TL_HI:VRAMP_TL_LO]);
    wire [VRAMP_CNT_W-1:0] len_r = vramp_run_len(zdur_reg[VRAMP_TR_HI:VRAMP_TR_LO]);

    // Zero-run qualification
    wire zero_l = (f_data.left == '0);
    wire zero_r = (f_data.right == '0);
    wire q_l = zcfg_reg[VRAMP_EN_L] && (zl_reg >= len_l);
    wire q_r = zcfg_reg[VRAMP_EN_R] && (zr_reg >= len_r);
    wire joint = zcfg_reg[VRAMP_JOINT];
    wire am_l = joint ? (q_l && q_r) : q_l;
    wire am_r = joint ? (q_l && q_r) : q_r;

    // Emergency ramp state machine
    wire upd = smp_tick && (div_reg >= div_lim);
    wire [8:0] vol_sum = {1'b0, vol_reg} + {1'b0, step_codes};
    always_comb
    begin
        st_next = st_reg;
        vol_next = vol_reg;
        case (st_reg)
            VRAMP_ST_IDLE:
            begin
                vol_next = digital_volume_level;
                if (emerg_trig)
                    st_next = (e_speed == VRAMP_SPD_INSTANT) ? VRAMP_ST_MUTED : VRAMP_ST_RAMP;
                if (emerg_trig && e_speed == VRAMP_SPD_INSTANT)
                    vol_next = VRAMP_VOL_MUTE;
            end
            VRAMP_ST_RAMP:
            begin
                if (e_speed == VRAMP_SPD_INSTANT)
                begin
                    vol_next = VRAMP_VOL_MUTE;
                    st_next = VRAMP_ST_MUTED;
                end
                else if (upd)
                begin
                    // Saturate at the mute code
                    vol_next = (vol_sum >= {1'b0, VRAMP_VOL_MUTE}) ? VRAMP_VOL_MUTE : vol_sum[7:0];
                    if (vol_sum >= {1'b0, VRAMP_VOL_MUTE})
                        st_next = VRAMP_ST_MUTED;
                end
            end
            VRAMP_ST_MUTED:
            begin
                vol_next = VRAMP_VOL_MUTE;
                if (!emerg_trig)
                    st_next = VRAMP_ST_IDLE;
            end
            default:
                st_next = VRAMP_ST_IDLE;
        endcase
    end

    // Control registers
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            emerg_reg <= VRAMP_RST_EMERG;
            zcfg_reg <= VRAMP_RST_ZCFG;
            zdur_reg <= VRAMP_RST_ZDUR;
            rdata_reg <= 8'h00;
        end
        else
        begin
            if (wr_emerg)
                emerg_reg <= reg_req.data;
            if (wr_zcfg)
                zcfg_reg <= reg_req.data;
            if (wr_zdur)
                zdur_reg <= reg_req.data;
            rdata_reg <= rdata_next;
        end
    end

    // Zero-run counters, saturating; nonzero sample clears
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            zl_reg <= '0;
            zr_reg <= '0;
        end
        else if (smp_tick)
        begin
            zl_reg <= !zero_l ? '0 : (zl_reg == '1) ? zl_reg : zl_reg + 1'b1;
            zr_reg <= !zero_r ? '0 : (zr_reg == '1) ? zr_reg : zr_reg + 1'b1;
        end
    end

    // Ramp state, update divider and output stage
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            st_reg <= VRAMP_ST_IDLE;
            vol_reg <= VRAMP_VOL_UNITY;
            div_reg <= '0;
            mute_l_reg <= 1'b0;
            mute_r_reg <= 1'b0;
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
            emerg_act_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            emerg_act_reg <= (st_next != VRAMP_ST_IDLE);
            vol_reg <= vol_next;
            if (st_reg != VRAMP_ST_RAMP || upd)
                div_reg <= '0;
            else if (smp_tick)
                div_reg <= div_reg + 1'b1;
            mute_l_reg <= am_l;
            mute_r_reg <= am_r;
            if (smp_tick)
            begin
                out_valid_reg <= 1'b1;
                out_data_reg <= f_data;
            end
            else if (out_ready)
                out_valid_reg <= 1'b0;
        end
    end

    assign reg_rdata = rdata_reg;
    assign volume_out = vol_reg;
    assign mute_left = mute_l_reg;
    assign mute_right = mute_r_reg;
    assign emerg_active = emerg_act_reg;
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;

    // Checks
    a_instant_mute: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st_reg == VRAMP_ST_IDLE && emerg_trig && e_speed == VRAMP_SPD_INSTANT) |=> vol_reg == VRAMP_VOL_MUTE)
        else $error("instant mute not applied");
    a_ramp_step: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st_reg == VRAMP_ST_RAMP && upd && e_speed != VRAMP_SPD_INSTANT && vol_sum < 9'h0ff)
        |=> vol_reg == $past(vol_reg) + $past(step_codes))
        else $error("ramp step size wrong");
    a_ramp_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st_reg == VRAMP_ST_RAMP && !upd && e_speed != VRAMP_SPD_INSTANT) |=> $stable(vol_reg))
        else $error("volume moved between updates");
    a_div_bound: assert property (@(posedge clk_sys) disable iff (!nrst)
        div_reg <= VRAMP_DIV_MAX)
        else $error("update divider overran");
    a_trig_enter: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st_reg == VRAMP_ST_IDLE && emerg_trig) |=> st_reg != VRAMP_ST_IDLE)
        else $error("fault did not start ramp");
    a_left_enable: assert property (@(posedge clk_sys) disable iff (!nrst)
        !zcfg_reg[VRAMP_EN_L] |=> !mute_l_reg)
        else $error("left muted while disabled");
    a_right_enable: assert property (@(posedge clk_sys) disable iff (!nrst)
        !zcfg_reg[VRAMP_EN_R] |=> !mute_r_reg)
        else $error("right muted while disabled");
    a_joint_mute: assert property (@(posedge clk_sys) disable iff (!nrst)
        (joint && !(q_l && q_r)) |=> (!mute_l_reg && !mute_r_reg))
        else $error("joint mode muted one side");
    a_indep_mute: assert property (@(posedge clk_sys) disable iff (!nrst)
        (!joint && q_l) |=> mute_l_reg)
        else $error("independent left mute missing");
    a_run_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
        (smp_tick && !zero_l) |=> (zl_reg == '0) ##1 !mute_l_reg)
        else $error("nonzero sample did not clear run");
    a_run_len: assert property (@(posedge clk_sys) disable iff (!nrst)
        (zdur_reg[VRAMP_TL_HI:VRAMP_TL_LO] == 3'h0) |-> (len_l == VRAMP_CNT_W'(1104)))
        else $error("shortest run length wrong");
    // Idle volume tracks the normal path one cycle later
    a_idle_track: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st_reg == VRAMP_ST_IDLE && !emerg_trig) |=> vol_reg == $past(digital_volume_level))
        else $error("idle volume not tracking");
    a_mute_stay: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st_reg == VRAMP_ST_MUTED) |=> vol_reg == VRAMP_VOL_MUTE)
        else $error("muted state left the mute code");
    a_out_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        (out_valid_reg && !out_ready) |=> (out_valid_reg && $stable(out_data_reg)))
        else $error("output word dropped while stalled");
    // Zero runs count one per consumed zero sample and hold while no sample is consumed
    a_left_count: assert property (@(posedge clk_sys) disable iff (!nrst)
        (smp_tick && zero_l && zl_reg != '1) |=> zl_reg == $past(zl_reg) + 1'b1)
        else $error("left zero run not counted");
    a_right_count: assert property (@(posedge clk_sys) disable iff (!nrst)
        (smp_tick && zero_r && zr_reg != '1) |=> zr_reg == $past(zr_reg) + 1'b1)
        else $error("right zero run not counted");
    a_count_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        !smp_tick |=> ($stable(zl_reg) && $stable(zr_reg)))
        else $error("zero run moved without a sample");
    a_joint_both: assert property (@(posedge clk_sys) disable iff (!nrst)
        (joint && q_l && q_r) |=> (mute_l_reg && mute_r_reg))
        else $error("joint mode failed to mute both");
    // Main scenarios worth seeing at least once
    c_joint: cover property (@(posedge clk_sys) joint && mute_l_reg && mute_r_reg);
    c_ramp: cover property (@(posedge clk_sys) st_reg == VRAMP_ST_RAMP ##1 st_reg == VRAMP_ST_MUTED);
    c_instant: cover property (@(posedge clk_sys) st_reg == VRAMP_ST_IDLE ##1 st_reg == VRAMP_ST_MUTED);
    c_left_mute: cover property (@(posedge clk_sys) $rose(mute_l_reg));
    c_fifo_full: cover property (@(posedge clk_sys) !smp_ready);
endmodule // vramp_top

// Input buffer; a full buffer pushes back on the source rather than losing a sample
module vramp_fifo
    import vramp_pkg::*;
#(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Write side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Read side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    // Honest full and empty
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rp_reg];
    // Pointers and storage
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                mem_reg[wp_reg] <= in_data;
                wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
            end
            if (pop)
                rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Occupancy never passes the depth, and the head word holds while unread
    a_fifo_bound: assert property (@(posedge clk_sys) disable iff (!nrst)
        cnt_reg <= (AW+1)'(DEPTH))
        else $error("buffer count overran");
    a_fifo_head: assert property (@(posedge clk_sys) disable iff (!nrst)
        (out_valid && !out_ready) |=> $stable(out_data))
        else $error("buffer head changed while stalled");
endmodule // vramp_fifo
